// >>> hall_cond_regs.svh
// constants of the field signal conditioning path
// assumes a 250 MHz system clock; included by its bare name
`ifndef HALL_COND_REGS_SVH
`define HALL_COND_REGS_SVH
// program port word indices
`define IDX_MODE 4'h0
`define IDX_LIN_COEF 4'h1
`define IDX_QUAD_COEF 4'h2
`define IDX_TCGRP 4'h3
`define IDX_GAIN 4'h4
`define IDX_OFFS 4'h5
`define IDX_CLLO 4'h6
`define IDX_CLHI 4'h7
`define IDX_LOCK 4'h8
// converter_output_config fields
`define MODE_RNG_HI 9
`define MODE_FMT_HI 7
`define MODE_FMT_LO 5
`define MODE_FLT_HI 4
`define MODE_FLT_LO 3
`define MODE_RNG_LO_HI 2
`define MODE_RNG_LO_LO 1
// reset values and output maximum
`define RST_MODE 10'h000
`define RST_LIN_COEF 5'h0f
`define RST_QUAD_COEF 3'h1
`define RST_TCGRP 2'h1
`define RST_GAIN 14'h0800
`define RST_OFFS 15'h2000
`define RST_CLLO 14'h0000
`define RST_CLHI 14'h3fff
`define OUT_MAX 14'h3fff
// timing
`define CLK_PERIOD_NS 4
`define SAMPLE_NS 1000
`define SAMPLE_CYC (`SAMPLE_NS / `CLK_PERIOD_NS)
`define PWM_PERIOD_NS 8000000
`define PWM_STEPS 2048
`define PWM_STEP_CYC (`PWM_PERIOD_NS / `CLK_PERIOD_NS / `PWM_STEPS)
`define MUX_HOLD_NS 2000000
`define MUX_HOLD_CYC (`MUX_HOLD_NS / `CLK_PERIOD_NS)
`endif

// >>> hall_cond_pkg.sv
// types of the field signal conditioning path
// assumes nothing beyond the regs header
package hall_cond_pkg;
  typedef enum logic [2:0] {FMT_ANALOG, FMT_MUX_CONT, FMT_MUX_EXT, FMT_BURN, FMT_PWM, FMT_PWM_INV} fmt_t;
  typedef enum logic [2:0] {RNG_15, RNG_30, RNG_60, RNG_80, RNG_100, RNG_150} range_t;
  typedef enum logic {HALF_LOW, HALF_HIGH} half_t;
endpackage

// >>> hall_cond.sv
// field signal conditioning path: filter, gain, offset, clamp, output format
// assumes converter samples and die temperature arrive synchronous to clk_sys_in
//
// Contract
// - filter, gain, offset, then clamp before output
// - processed value stays within 0 to 16383
// - mode word field layout bits 9..0
// - range code from bit 9 and bits 2:1
// - bits 4:3 pick filter corner frequency
// - bits 7:5 pick output format
// - analog format drives 12-bit ratiometric code
// - multiplex splits 14 bits into halves
// - pull direction selects half in triggered mode
// - continuous multiplex sends low then high
// - burn-in drives path from internal saw-tooth
// - pwm: 11-bit duty, 8 ms period
// - duty loads only at period start
// - inverted pwm outputs 100 percent minus duty
// - gain drift uses 5-bit and 3-bit coefficients
// - four coefficient groups; two barred at 15 mT
// - gain signed, -4 to 4, fine steps
// - raw converter value readable separately
// - lock bit blocks all configuration writes
// - processed readback delivered bit reversed
// - processed readback zero outside analog format
// - new lock acts after next power cycle
`timescale 1ns/1ps
`default_nettype none
`include "hall_cond_regs.svh"

// sample buffer between converter and processing
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg, rp_reg;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;
  assign push = wr_valid_in && wr_ready_out;
  assign pop = rd_valid_out && rd_ready_in;
  // next fill level; ready is registered from it so the pin comes from a flop
  assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign rd_valid_out = cnt_reg != '0;
  assign rd_data_out = mem[rp_reg];
  // storage
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wp_reg] <= wr_data_in;
    end
  end
  // pointers and fill level
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      wr_ready_out <= 1'b1;
    end else begin
      if (push) wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
      if (pop) rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
      cnt_reg <= cnt_next;
      wr_ready_out <= cnt_next != (AW+1)'(DEPTH);
    end
  end
endmodule

module hall_cond #(
  parameter int SAMPLE_CYC = `SAMPLE_CYC,
  parameter int PWM_STEP_CYC = `PWM_STEP_CYC,
  parameter int MUX_HOLD_CYC = `MUX_HOLD_CYC,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic factory_erase_in,
  input wire logic [15:0] adc_data_in,
  input wire logic adc_valid_in,
  output logic adc_ready_out,
  input wire logic signed [7:0] temp_delta_in,
  input wire logic prog_wr_in,
  input wire logic [3:0] prog_idx_in,
  input wire logic [14:0] prog_data_in,
  input wire logic pull_up_in,
  output logic [11:0] dac_code_out,
  output logic pwm_out,
  output hall_cond_pkg::half_t mux_half_out,
  output hall_cond_pkg::range_t range_sel_out,
  output logic [15:0] raw_readback_out,
  output logic [13:0] proc_readback_out,
  output logic lock_active_out
);
  import hall_cond_pkg::*;

  // non-volatile settings survive rst_n_in; only the erase strobe blanks them
  logic [9:0] mode_reg;
  logic [4:0] lin_coef_reg;
  logic [2:0] quad_coef_reg;
  logic [1:0] tcgrp_reg;
  logic [13:0] gain_reg;
  logic [14:0] offs_reg;
  logic [13:0] cllo_reg, clhi_reg;
  logic lock_stored_reg;
  logic cfg_wr;
  assign cfg_wr = prog_wr_in && !lock_active_out;
  always_ff @(posedge clk_sys_in) begin
    if (factory_erase_in) begin
      mode_reg <= `RST_MODE;
      lin_coef_reg <= `RST_LIN_COEF;
      quad_coef_reg <= `RST_QUAD_COEF;
      tcgrp_reg <= `RST_TCGRP;
      gain_reg <= `RST_GAIN;
      offs_reg <= `RST_OFFS;
      cllo_reg <= `RST_CLLO;
      clhi_reg <= `RST_CLHI;
      lock_stored_reg <= 1'b0;
    end else if (cfg_wr) begin
      unique case (prog_idx_in)
        `IDX_MODE: mode_reg <= prog_data_in[9:0];
        `IDX_LIN_COEF: lin_coef_reg <= prog_data_in[4:0];
        `IDX_QUAD_COEF: quad_coef_reg <= prog_data_in[2:0];
        `IDX_TCGRP: tcgrp_reg <= prog_data_in[1:0];
        `IDX_GAIN: gain_reg <= prog_data_in[13:0];
        `IDX_OFFS: offs_reg <= prog_data_in;
        `IDX_CLLO: cllo_reg <= prog_data_in[13:0];
        `IDX_CLHI: clhi_reg <= prog_data_in[13:0];
        `IDX_LOCK: lock_stored_reg <= lock_stored_reg | prog_data_in[0];
        default: ;
      endcase
    end
  end

  // lock takes hold only when reset (power-up) samples it
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) lock_active_out <= lock_stored_reg;
  end

  // mode word decode
  function automatic fmt_t fmt_of(input logic [2:0] b);
    unique case (b)
      3'h1: fmt_of = FMT_MUX_CONT;
      3'h3: fmt_of = FMT_MUX_EXT;
      3'h2: fmt_of = FMT_BURN;
      3'h6: fmt_of = FMT_PWM;
      3'h7: fmt_of = FMT_PWM_INV;
      default: fmt_of = FMT_ANALOG;
    endcase
  endfunction
  function automatic range_t range_of(input logic hi, input logic [1:0] lo);
    unique case ({hi, lo})
      3'h4: range_of = RNG_15;
      3'h1: range_of = RNG_60;
      3'h2: range_of = RNG_80;
      3'h3: range_of = RNG_100;
      3'h7: range_of = RNG_150;
      default: range_of = RNG_30;
    endcase
  endfunction
  fmt_t fmt;
  range_t rng;
  logic [3:0] flt_shift;
  assign fmt = fmt_of(mode_reg[`MODE_FMT_HI:`MODE_FMT_LO]);
  assign rng = range_of(mode_reg[`MODE_RNG_HI], mode_reg[`MODE_RNG_LO_HI:`MODE_RNG_LO_LO]);
  // corner to one-pole shift at the sample rate: 80 Hz, 2 kHz, 500 Hz, 1 kHz
  always_comb begin
    unique case (mode_reg[`MODE_FLT_HI:`MODE_FLT_LO])
      2'h0: flt_shift = 4'hb;
      2'h1: flt_shift = 4'h6;
      2'h2: flt_shift = 4'h8;
      default: flt_shift = 4'h7;
    endcase
  end

  // converter range steering
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) range_sel_out <= RNG_30;
    else range_sel_out <= rng;
  end

  // sample tick divider
  logic [15:0] smp_cnt_reg;
  logic tick;
  assign tick = smp_cnt_reg == 16'(SAMPLE_CYC - 1);
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || tick) smp_cnt_reg <= '0;
    else smp_cnt_reg <= smp_cnt_reg + 16'h0001;
  end

  // converter samples are buffered and drained one per tick
  logic [15:0] fifo_data;
  logic fifo_valid, take;
  sample_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .wr_data_in(adc_data_in),
    .wr_valid_in(adc_valid_in),
    .wr_ready_out(adc_ready_out),
    .rd_data_out(fifo_data),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(tick)
  );
  assign take = tick && fifo_valid;

  // raw converter readback and burn-in saw-tooth
  logic [15:0] saw_reg;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      raw_readback_out <= '0;
      saw_reg <= '0;
    end else begin
      if (take) raw_readback_out <= fifo_data;
      if (tick) saw_reg <= saw_reg + 16'h0040;
    end
  end

  // low-pass filter on the field or stimulus
  logic signed [31:0] acc_reg;
  logic signed [15:0] fin;
  logic step;
  assign fin = (fmt == FMT_BURN) ? $signed(saw_reg) : $signed(fifo_data);
  assign step = (fmt == FMT_BURN) ? tick : take;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) acc_reg <= '0;
    else if (step) acc_reg <= acc_reg + (($signed({{4{fin[15]}}, fin, 12'h000}) - acc_reg) >>> flt_shift);
  end

  // gain drift over temperature, slope in ppm/K per group
  function automatic logic signed [12:0] coef_slope(input logic [1:0] g, input logic [4:0] lc);
    unique case (g)
      2'h0: coef_slope = 13'sd0 - 13'sd3100 + 13'(lc * 42);
      2'h2: coef_slope = 13'sd0 - 13'sd1750 + 13'(lc * 39);
      2'h3: coef_slope = 13'sd450 + 13'(lc * 18);
      default: coef_slope = 13'sd0 - 13'sd500 + 13'(lc * 31);
    endcase
  endfunction
  logic [1:0] grp;
  logic signed [12:0] slope;
  logic signed [3:0] quad;
  logic signed [23:0] corr;
  logic signed [39:0] gprod;
  logic signed [14:0] gain_eff;
  // groups barred at the narrowest range fall back to the default group
  assign grp = (rng == RNG_15 && !tcgrp_reg[0]) ? `RST_TCGRP : tcgrp_reg;
  assign slope = coef_slope(grp, lin_coef_reg);
  assign quad = $signed({1'b0, quad_coef_reg}) - 4'sd5;
  assign corr = 24'(slope * temp_delta_in) + 24'(quad * temp_delta_in * temp_delta_in);
  assign gprod = 40'($signed(gain_reg) * corr);
  // gain is Q2.11: -4 to just under 4
  assign gain_eff = $signed({gain_reg[13], gain_reg}) + 15'(gprod >>> 20);

  // multiply, add offset, clamp; one cycle after the filter step
  logic signed [31:0] fval, prod, sum, lo, hi;
  logic [13:0] res_reg;
  logic res_new_reg;
  assign fval = acc_reg >>> 12;
  assign prod = (fval * gain_eff) >>> 11;
  assign sum = prod + $signed({{17{offs_reg[14]}}, offs_reg});
  assign lo = $signed({18'h0, cllo_reg});
  assign hi = $signed({18'h0, clhi_reg});
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      res_reg <= '0;
      res_new_reg <= 1'b0;
    end else begin
      res_new_reg <= step;
      if (res_new_reg) begin
        if (sum < lo || sum < 0) res_reg <= (lo < 0) ? 14'h0000 : cllo_reg;
        else if (sum > hi) res_reg <= clhi_reg;
        else if (sum > 32'sd16383) res_reg <= `OUT_MAX;
        else res_reg <= sum[13:0];
      end
    end
  end

  // processed readback: bit reversed, live only in analog format
  function automatic logic [13:0] rev14(input logic [13:0] v);
    for (int i = 0; i < 14; i++) rev14[i] = v[13-i];
  endfunction
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) proc_readback_out <= '0;
    else if (fmt == FMT_ANALOG) proc_readback_out <= rev14(res_reg);
    else proc_readback_out <= '0;
  end

  // continuous multiplex half timer
  logic [23:0] hold_cnt_reg;
  half_t cont_half_reg, half;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || fmt != FMT_MUX_CONT) begin
      hold_cnt_reg <= '0;
      cont_half_reg <= HALF_LOW;
    end else if (hold_cnt_reg == 24'(MUX_HOLD_CYC - 1)) begin
      hold_cnt_reg <= '0;
      cont_half_reg <= (cont_half_reg == HALF_LOW) ? HALF_HIGH : HALF_LOW;
    end else begin
      hold_cnt_reg <= hold_cnt_reg + 24'h000001;
    end
  end
  assign half = (fmt == FMT_MUX_EXT) ? (pull_up_in ? HALF_HIGH : HALF_LOW) : cont_half_reg;

  // analog code per format
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      dac_code_out <= '0;
      mux_half_out <= HALF_LOW;
    end else begin
      mux_half_out <= half;
      unique case (fmt)
        FMT_ANALOG, FMT_BURN: dac_code_out <= res_reg[13:2];
        FMT_MUX_CONT, FMT_MUX_EXT:
          dac_code_out <= {(half == HALF_HIGH) ? res_reg[13:7] : res_reg[6:0], 5'h00};
        default: dac_code_out <= '0;
      endcase
    end
  end

  // pwm: step enable, 11-bit phase, duty latched at period start
  logic [15:0] pstep_reg;
  logic [10:0] phase_reg, duty_reg;
  logic pen;
  assign pen = pstep_reg == 16'(PWM_STEP_CYC - 1);
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || pen) pstep_reg <= '0;
    else pstep_reg <= pstep_reg + 16'h0001;
  end
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      phase_reg <= '0;
      duty_reg <= '0;
    end else if (pen) begin
      phase_reg <= phase_reg + 11'h001;
      if (phase_reg == 11'h7ff) duty_reg <= res_reg[13:3];
    end
  end
  // the host reads duty at the falling edge since in FMT_PWM rising edges carry updates
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) pwm_out <= 1'b0;
    else if (fmt == FMT_PWM) pwm_out <= phase_reg < duty_reg;
    else if (fmt == FMT_PWM_INV) pwm_out <= phase_reg >= duty_reg;
    else pwm_out <= 1'b0;
  end

  // checks
  // out-of-range sums saturate to a clamp instead of wrapping
  a_res_range: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    res_new_reg && (sum > 32'sd16383 || sum < 0)
    |=> res_reg == (($past(sum) < 0) ? $past(cllo_reg) : $past(clhi_reg)))
    else $error("processed value not confined");
  a_clamp_bounds: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    res_new_reg && cllo_reg <= clhi_reg && $stable(cllo_reg) && $stable(clhi_reg)
    |=> res_reg >= $past(cllo_reg) && res_reg <= $past(clhi_reg)) else $error("clamp not honoured");
  a_readback_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    fmt != FMT_ANALOG |=> proc_readback_out == '0) else $error("readback not zero");
  a_readback_rev: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    fmt == FMT_ANALOG |=> proc_readback_out[0] == $past(res_reg[13])
    && proc_readback_out[13] == $past(res_reg[0])) else $error("readback not reversed");
  a_duty_load: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $changed(duty_reg) |-> phase_reg == 11'h000) else $error("duty changed mid period");
  a_pwm_inv: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    fmt == FMT_PWM_INV && $stable(fmt) |=> pwm_out == ($past(phase_reg) >= $past(duty_reg)))
    else $error("inverted pwm wrong");
  a_lock_block: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in || factory_erase_in)
    lock_active_out |=> $stable(mode_reg) && $stable(gain_reg) && $stable(offs_reg))
    else $error("write passed lock");
  a_lock_late: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(lock_stored_reg) && !lock_active_out |=> !lock_active_out [*2])
    else $error("lock acted early");
  a_ext_half: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    fmt == FMT_MUX_EXT && pull_up_in |=> mux_half_out == HALF_HIGH
    && dac_code_out[11:5] == $past(res_reg[13:7])) else $error("wrong half sent");
  // a half only flips after it has stood its full hold time
  a_cont_order: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    fmt == FMT_MUX_CONT && $past(fmt) == FMT_MUX_CONT && $changed(cont_half_reg)
    |-> $past(hold_cnt_reg) == 24'(MUX_HOLD_CYC - 1)) else $error("continuous half timing broken");
  a_analog_code: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    fmt == FMT_ANALOG |=> dac_code_out == $past(res_reg[13:2])) else $error("analog code wrong");
  c_pwm_period: cover property (@(posedge clk_sys_in) fmt == FMT_PWM && $changed(duty_reg));
  c_mux_cont: cover property (@(posedge clk_sys_in) fmt == FMT_MUX_CONT && $rose(cont_half_reg));
  c_clamp_hit: cover property (@(posedge clk_sys_in) res_new_reg ##1 res_reg == clhi_reg);
  c_fifo_full: cover property (@(posedge clk_sys_in) !adc_ready_out);
endmodule
`default_nettype wire

// >>> ecu_model.sv
// engine control unit model: picks the multiplex half by pulling the pin
// and measures the pwm wave; assumes pwm_in is synchronous to clk_sys_in
`timescale 1ns/1ps
`default_nettype none
module ecu_model (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic pwm_in,
  input wire logic want_high_in,
  output logic pull_up_out,
  output logic [15:0] high_cyc_out,
  output logic [15:0] period_cyc_out,
  output logic [7:0] meas_cnt_out
);
  logic pwm_prev_reg;
  logic [15:0] run_reg;
  // pull up asks for the high half, pull down for the low half
  assign pull_up_out = want_high_in;
  // high time latched at the falling edge, period between rising edges
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      pwm_prev_reg <= 1'b0;
      run_reg <= 16'h0000;
      high_cyc_out <= 16'h0000;
      period_cyc_out <= 16'h0000;
      meas_cnt_out <= 8'h00;
    end else begin
      pwm_prev_reg <= pwm_in;
      run_reg <= run_reg + 16'h0001;
      if (pwm_in && !pwm_prev_reg) begin
        period_cyc_out <= run_reg;
        run_reg <= 16'h0001;
        meas_cnt_out <= meas_cnt_out + 8'h01;
      end
      if (!pwm_in && pwm_prev_reg) begin
        high_cyc_out <= run_reg;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb_hall_cond.sv
// self-checking bench of the field conditioning path with an ecu model
// assumes the design files and ecu_model.sv are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "hall_cond_regs.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end
module tb_hall_cond;
  import hall_cond_pkg::*;
  localparam int STEP = 2;
  localparam int HOLD = 16;
  localparam logic [13:0] CLV = 14'h1234;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic factory_erase_in = 1'b1;
  logic [15:0] adc_data_in = 16'h0000;
  logic adc_valid_in = 1'b0;
  logic signed [7:0] temp_delta_in = 8'sh00;
  logic prog_wr_in = 1'b0;
  logic [3:0] prog_idx_in = 4'h0;
  logic [14:0] prog_data_in = 15'h0000;
  logic want_high = 1'b0;
  logic pull_up, adc_ready_out, pwm_out, lock_active_out, acc, rst_prev;
  logic [11:0] dac_code_out;
  logic [15:0] raw_readback_out, raw_prev, e_raw, high_cyc, period_cyc;
  logic [13:0] proc_readback_out;
  logic [7:0] meas_cnt;
  half_t mux_half_out;
  range_t range_sel_out;
  logic [15:0] exp_q[$];
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int fc = 0;
  int feed_mode = 0;
  logic [2:0] rcode[6] = '{3'b100, 3'b000, 3'b001, 3'b010, 3'b011, 3'b111};
  range_t rexp[6] = '{RNG_15, RNG_30, RNG_60, RNG_80, RNG_100, RNG_150};
  logic [2:0] fcode[5] = '{3'b001, 3'b011, 3'b010, 3'b110, 3'b111};

  always #2 clk_sys_in = ~clk_sys_in;

  hall_cond #(.SAMPLE_CYC(8), .PWM_STEP_CYC(STEP), .MUX_HOLD_CYC(HOLD)) dut_u (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .factory_erase_in(factory_erase_in),
    .adc_data_in(adc_data_in), .adc_valid_in(adc_valid_in), .adc_ready_out(adc_ready_out),
    .temp_delta_in(temp_delta_in), .prog_wr_in(prog_wr_in), .prog_idx_in(prog_idx_in),
    .prog_data_in(prog_data_in), .pull_up_in(pull_up), .dac_code_out(dac_code_out),
    .pwm_out(pwm_out), .mux_half_out(mux_half_out), .range_sel_out(range_sel_out),
    .raw_readback_out(raw_readback_out), .proc_readback_out(proc_readback_out),
    .lock_active_out(lock_active_out));

  ecu_model ecu_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .pwm_in(pwm_out),
    .want_high_in(want_high), .pull_up_out(pull_up), .high_cyc_out(high_cyc),
    .period_cyc_out(period_cyc), .meas_cnt_out(meas_cnt));

  function automatic logic [13:0] rev14(input logic [13:0] v);
    logic [13:0] r;
    for (int i = 0; i < 14; i++) r[i] = v[13-i];
    return r;
  endfunction

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic prog(input logic [3:0] idx, input logic [14:0] d);
    prog_wr_in = 1'b1;
    prog_idx_in = idx;
    prog_data_in = d;
    wt(1);
    prog_wr_in = 1'b0;
    wt(1);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // converter source: notes each accepted sample, then offers a differing one
  always @(posedge clk_sys_in) begin
    acc = adc_valid_in && adc_ready_out;
    if (acc) exp_q.push_back(adc_data_in);
    fc++;
    #1;
    if (acc || !adc_valid_in) begin
      adc_valid_in = (feed_mode == 1) || (feed_mode == 2 && fc % 16 == 0);
      if (adc_valid_in) begin
        e_raw = 16'($urandom);
        adc_data_in = (e_raw == adc_data_in) ? e_raw ^ 16'h0001 : e_raw;
        temp_delta_in = 8'($signed($urandom % 41) - 20);
      end
    end
  end

  // raw readback watcher: each new value is the oldest noted sample
  always @(posedge clk_sys_in) begin
    if (rst_n_in && rst_prev && raw_readback_out !== raw_prev) begin
      if (exp_q.size() == 0) `CHK("raw_extra", 1'b1, 1'b0)
      else begin
        e_raw = exp_q.pop_front();
        `CHK("raw_readback", e_raw, raw_readback_out)
      end
    end
    raw_prev = raw_readback_out;
    rst_prev = rst_n_in;
  end

  // hang guard, well above the expected run of about 22000 cycles
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    int n;
    logic [15:0] duty;
    void'($urandom(32'h137c3ab8));
    wt(1);
    factory_erase_in = 1'b0;
    wt(11);
    `CHK("lock_at_erase", 1'b0, lock_active_out)
    rst_n_in = 1'b1;
    wt(1);
    for (int i = 1; i < 6; i++) prog(4'(i), 15'($urandom));
    feed_mode = 2;
    // the code of each of the six ranges in the mode word
    for (int i = 0; i < 6; i++) begin
      prog(`IDX_MODE, {5'h00, rcode[i][2], 1'b0, 3'b000, 2'b00, rcode[i][1:0], 1'b0});
      wt(40);
      `CHK("range_sel", rexp[i], range_sel_out)
    end
    // fill the sample buffer until it refuses, then drain it
    feed_mode = 1;
    n = 0;
    while (adc_ready_out !== 1'b0 && n < 50) begin wt(1); n++; end
    `CHK("fifo_full", 1'b0, adc_ready_out)
    feed_mode = 0;
    n = 0;
    while (exp_q.size() > 0 && n < 400) begin wt(1); n++; end
    wt(2);
    `CHK("fifo_drained", 1'b1, adc_ready_out)
    feed_mode = 2;
    // equal clamps pin the processed value whatever the field
    prog(`IDX_CLLO, {1'b0, CLV});
    prog(`IDX_CLHI, {1'b0, CLV});
    prog(`IDX_MODE, 15'h0000);
    wt(40);
    `CHK("dac_analog", CLV[13:2], dac_code_out)
    `CHK("proc_reversed", rev14(CLV), proc_readback_out)
    for (int i = 0; i < 5; i++) begin
      prog(`IDX_MODE, {7'h00, fcode[i], 5'h00});
      wt(40);
      `CHK("proc_zero", 14'h0000, proc_readback_out)
      case (fcode[i])
        3'b001: begin
          n = 0;
          while (mux_half_out === HALF_LOW && n < 100) begin wt(1); n++; end
          while (mux_half_out !== HALF_LOW && n < 100) begin wt(1); n++; end
          n = 0;
          while (mux_half_out === HALF_LOW && n < 100) begin wt(1); n++; end
          `CHK("mux_hold", HOLD, n)
          wt(2);
          `CHK("mux_cont_high", {CLV[13:7], 5'h00}, dac_code_out)
        end
        3'b011: begin
          want_high = 1'b1;
          wt(3);
          `CHK("half_up", HALF_HIGH, mux_half_out)
          `CHK("dac_high_half", {CLV[13:7], 5'h00}, dac_code_out)
          want_high = 1'b0;
          wt(3);
          `CHK("half_down", HALF_LOW, mux_half_out)
          `CHK("dac_low_half", {CLV[6:0], 5'h00}, dac_code_out)
        end
        3'b010: `CHK("dac_burn", CLV[13:2], dac_code_out)
        default: begin
          n = int'(meas_cnt) + 3;
          while (int'(meas_cnt) < n) wt(1); // the hang guard ends the run if edges stop
          duty = {5'h00, CLV[13:3]};
          `CHK("pwm_period", 16'(2048 * STEP), period_cyc)
          if (fcode[i] == 3'b110) `CHK("pwm_high", 16'(duty * STEP), high_cyc)
          else `CHK("pwm_inv_high", 16'((2048 - duty) * STEP), high_cyc)
        end
      endcase
    end
    // lock waits for the next power cycle, then refuses writes
    feed_mode = 0;
    n = 0;
    while (exp_q.size() > 0 && n < 400) begin wt(1); n++; end
    `CHK("drain_done", 0, exp_q.size())
    prog(`IDX_MODE, 15'h0002);
    prog(`IDX_LOCK, 15'h0001);
    wt(40);
    `CHK("range_before_lock", RNG_60, range_sel_out)
    `CHK("lock_pending", 1'b0, lock_active_out)
    rst_n_in = 1'b0;
    wt(2);
    rst_n_in = 1'b1;
    wt(1);
    `CHK("lock_active", 1'b1, lock_active_out)
    prog(`IDX_MODE, 15'h0006);
    wt(40);
    `CHK("range_locked", RNG_60, range_sel_out)
    final_report();
  end
endmodule
`default_nettype wire
